// *** src/open_phase_element.sv ***
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ns
module open_phase_element (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        meas_valid,
  input  wire logic [15:0] ia_mag,
  input  wire logic [15:0] ib_mag,
  input  wire logic [15:0] ic_mag,
  input  wire logic [15:0] i1_mag,
  input  wire logic [15:0] i2_mag,
  output logic             pickup_q,
  output logic             trip_q,
  output logic             alarm_q,
  output logic             irq_q
);
  import open_phase_pkg::*;

  open_phase_pkg::func_t func_q;
  logic [9:0]  ratio_set_q;
  logic [15:0] floor_q, ceil_q, delay_q;
  logic [15:0] prev_q [3];
  logic [2:0]  step_hit;
  logic [2:0]  step_q;
  logic [16:0] tick_cnt_q;
  logic [15:0] ms_cnt_q;
  logic [2:0]  irq_stat_q, irq_mask_q, irq_set;
  logic        latch_q;
  logic        ratio_over, ratio_drop, window_ok, one_phase, disabled;
  logic [25:0] i2_x1000, i1_x_set;
  logic [31:0] i2_x_drop, i1_x_drop;
  logic        wr, rd, tick;
  logic        pickup_d, trip_d;
  logic [31:0] rd_d;
  logic        map_hit;

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign disabled = (func_q == FN_DISABLED);

  // i2/i1 > r/1000 without a divider: i2*1000 > r*i1, with 1000 built as 1024 - 32 + 8.
  assign i2_x1000   = {i2_mag, 10'h000} - {5'h00, i2_mag, 5'h00} + {7'h00, i2_mag, 3'h0};
  assign i1_x_set   = 26'(i1_mag) * 26'(ratio_set_q);
  assign ratio_over = i2_x1000 > i1_x_set;
  // The ratio side is scaled by 40 and the setting side by 39 so the 97.5 percent dropout stays an exact integer compare.
  assign i2_x_drop  = 32'(i2_x1000) * 32'(DROP_DEN);
  assign i1_x_drop  = 32'(i1_x_set) * 32'(DROP_NUM);
  assign ratio_drop = i2_x_drop < i1_x_drop;
  assign window_ok  = (i1_mag >= floor_q) && (i1_mag <= ceil_q);

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_step
      logic [15:0] cur;
      assign cur = (g == 0) ? ia_mag : (g == 1) ? ib_mag : ic_mag;
      assign step_hit[g] = ((cur > prev_q[g]) ? (cur - prev_q[g]) : (prev_q[g] - cur)) > STEP_LIMIT;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          prev_q[g] <= 16'h0000;
        end else if (meas_valid) begin
          prev_q[g] <= cur;
        end
      end
    end
  endgenerate

  // A step in exactly one phase is remembered while the function is enabled, the ratio stays over its setting and i1 stays inside the window.
  assign one_phase = (step_hit == 3'b001) || (step_hit == 3'b010) || (step_hit == 3'b100);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_q <= 3'h0;
    end else if (disabled || !ratio_over || !window_ok) begin
      step_q <= 3'h0;
    end else if (meas_valid && one_phase) begin
      step_q <= step_hit;
    end
  end

  // Pickup holds once set until the ratio falls under the dropout level, i1 leaves the window or the function is disabled.
  always_comb begin
    pickup_d = pickup_q;
    if (disabled || !window_ok) begin
      pickup_d = 1'b0;
    end else if (!pickup_q) begin
      pickup_d = ratio_over && (step_q != 3'h0 || (meas_valid && one_phase));
    end else if (ratio_drop) begin
      pickup_d = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pickup_q <= 1'b0;
    end else begin
      pickup_q <= pickup_d;
    end
  end

  assign tick = (tick_cnt_q == TICK_LAST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= 17'h00000;
      ms_cnt_q   <= 16'h0000;
    end else if (!pickup_q) begin
      tick_cnt_q <= 17'h00000;
      ms_cnt_q   <= 16'h0000;
    end else begin
      tick_cnt_q <= tick ? 17'h00000 : tick_cnt_q + 17'h00001;
      if (tick && ms_cnt_q != 16'hFFFF) begin
        ms_cnt_q <= ms_cnt_q + 16'h0001;
      end
    end
  end

  assign trip_d = pickup_q && pickup_d && (ms_cnt_q >= delay_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip_q <= 1'b0;
    end else begin
      trip_q <= trip_d && (func_q == FN_TRIP || func_q == FN_CONTROL);
    end
  end

  // A latched alarm outlives the condition; writing the clear bit releases it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_q <= 1'b0;
      alarm_q <= 1'b0;
    end else begin
      if (disabled || (wr && paddr == A_CTRL && pwdata[4])) begin
        latch_q <= 1'b0;
      end else if (trip_d && func_q == FN_LATCHED) begin
        latch_q <= 1'b1;
      end
      alarm_q <= (trip_d && func_q == FN_ALARM) || latch_q ||
                 (trip_d && func_q == FN_LATCHED);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      func_q      <= FN_DISABLED;
      ratio_set_q <= RATIO_RST;
      floor_q     <= FLOOR_RST;
      ceil_q      <= CEIL_RST;
      delay_q     <= DELAY_RST;
      irq_mask_q  <= 3'h0;
    end else if (wr) begin
      unique case (paddr)
        A_CTRL: begin
          if (pwdata[2:0] <= 3'h4) begin
            func_q <= open_phase_pkg::func_t'(pwdata[2:0]);
          end
        end
        A_RATIO: begin
          if (pwdata[9:0] >= RATIO_MIN && pwdata[9:0] <= RATIO_MAX && pwdata[31:10] == 22'h0) begin
            ratio_set_q <= pwdata[9:0];
          end
        end
        A_FLOOR: begin
          if (pwdata[15:0] >= FLOOR_MIN && pwdata[15:0] <= FLOOR_MAX) begin
            floor_q <= pwdata[15:0];
          end
        end
        A_CEIL: begin
          if (pwdata[15:0] >= CEIL_MIN && pwdata[15:0] <= CEIL_MAX) begin
            ceil_q <= pwdata[15:0];
          end
        end
        A_DELAY: begin
          if (pwdata[15:0] <= DELAY_MAX) begin
            delay_q <= pwdata[15:0];
          end
        end
        A_IRQ_MASK: irq_mask_q <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  assign irq_set[IRQ_PKP_BIT]  = pickup_d && !pickup_q;
  assign irq_set[IRQ_TRIP_BIT] = trip_d && !trip_q;
  assign irq_set[IRQ_DROP_BIT] = pickup_q && !pickup_d;

  // Set wins over a write-one clear in the same cycle.
  // A mask bit of one lets its status bit reach the interrupt, so all are blocked after reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= 3'h0;
      irq_q      <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~((wr && paddr == A_IRQ_STAT) ? pwdata[2:0] : 3'h0)) | irq_set;
      irq_q      <= |(irq_stat_q & irq_mask_q);
    end
  end

  always_comb begin
    map_hit = 1'b1;
    rd_d    = 32'h0000_0000;
    unique case (paddr)
      A_CTRL:     rd_d = {29'h0, func_q};
      A_RATIO:    rd_d = {22'h0, ratio_set_q};
      A_FLOOR:    rd_d = {16'h0, floor_q};
      A_CEIL:     rd_d = {16'h0, ceil_q};
      A_DELAY:    rd_d = {16'h0, delay_q};
      A_STATE:    rd_d = {ms_cnt_q, 9'h0, step_q, alarm_q, latch_q, trip_q, pickup_q};
      A_IRQ_STAT: rd_d = {29'h0, irq_stat_q};
      A_IRQ_MASK: rd_d = {29'h0, irq_mask_q};
      default:    map_hit = 1'b0;
    endcase
  end

  // Read data is registered in setup so the access phase completes at once.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      if (rd) begin
        prdata <= rd_d;
      end
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !map_hit;
    end
  end

  property p_trip_needs_pickup;
    @(posedge pclk) disable iff (!presetn) trip_q |-> $past(pickup_q);
  endproperty
  a_trip_needs_pickup: assert property (p_trip_needs_pickup) else $error("trip without pickup");

  sequence s_disabled_quiet;
    (!pickup_q && !trip_q) ##1 (ms_cnt_q == 16'h0);
  endsequence

  property p_disabled_clear;
    @(posedge pclk) disable iff (!presetn) (func_q == FN_DISABLED) |=> s_disabled_quiet;
  endproperty
  a_disabled_clear: assert property (p_disabled_clear) else $error("disabled but active");

  property p_timer_clear;
    @(posedge pclk) disable iff (!presetn) !pickup_q |=> tick_cnt_q == 17'h0 && ms_cnt_q == 16'h0;
  endproperty
  a_timer_clear: assert property (p_timer_clear) else $error("timer not cleared");

  property p_window;
    @(posedge pclk) disable iff (!presetn) !window_ok |=> !pickup_q;
  endproperty
  a_window: assert property (p_window) else $error("pickup outside window");

  sequence s_drop_quiet;
    !pickup_q ##1 !trip_q;
  endsequence

  property p_drop;
    @(posedge pclk) disable iff (!presetn) (pickup_q && ratio_drop) |=> s_drop_quiet;
  endproperty
  a_drop: assert property (p_drop) else $error("no dropout");

  property p_rise;
    @(posedge pclk) disable iff (!presetn) $rose(pickup_q) |-> $past(ratio_over) && $past(window_ok);
  endproperty
  a_rise: assert property (p_rise) else $error("bad pickup");

  property p_func_legal;
    @(posedge pclk) disable iff (!presetn) func_q <= FN_CONTROL && ratio_set_q >= RATIO_MIN;
  endproperty
  a_func_legal: assert property (p_func_legal) else $error("illegal setting");

  property p_ceiling;
    @(posedge pclk) disable iff (!presetn) (i1_mag > ceil_q) |=> !pickup_q;
  endproperty
  a_ceiling: assert property (p_ceiling) else $error("pickup above ceiling");

  property p_trip_wait;
    @(posedge pclk) disable iff (!presetn) (ms_cnt_q < delay_q) |=> !trip_q;
  endproperty
  a_trip_wait: assert property (p_trip_wait) else $error("trip before delay");

  property p_pickup_step;
    @(posedge pclk) disable iff (!presetn)
      $rose(pickup_q) |-> ($past(step_q) != 3'h0) || ($past(meas_valid) && $past(one_phase));
  endproperty
  a_pickup_step: assert property (p_pickup_step) else $error("pickup without step");

  property p_latch_hold;
    @(posedge pclk) disable iff (!presetn)
      (latch_q && !disabled && !(wr && paddr == A_CTRL && pwdata[4])) |=> latch_q;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched alarm lost");

  property p_apb_answer;
    @(posedge pclk) disable iff (!presetn) (psel && !penable) |=> pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("no bus answer");

  property p_irq_level;
    @(posedge pclk) disable iff (!presetn) (|(irq_stat_q & irq_mask_q)) |=> irq_q;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt not raised");
endmodule

// *** src/open_phase_pkg.sv ***
// What this block does
// - Pickup rises only when the sequence ratio is above its setting, positive-sequence current is inside the floor and ceiling,
//   and one single phase current has stepped by more than 0.05 times CT.
// - In Trip and Control, trip rises once pickup has been held without a break for the whole operate delay; Alarm and Latched Alarm raise alarm instead.
// - If the ratio falls below about 97 to 98 percent of its setting before the delay ends, pickup drops at once and no trip follows.
// - The ratio setting runs 20.0 to 100.0 percent in 0.1 percent steps, default 20.0, as negative over positive sequence current.
// - The positive-sequence floor runs 0.05 to 1.00 times CT in 0.01 steps, default 0.10, and detection is inhibited below it.
// - The positive-sequence ceiling runs 0.05 to 5.00 times CT in 0.01 steps, default 0.10, and above it the element does not operate.
// - The operate delay runs 0.000 to 60.000 seconds in 1 ms steps, default 20.000 seconds.
// - Function select offers Disabled, Trip, Alarm, Latched Alarm and Control, and resets to Disabled.
// - Sequence magnitudes come from the phase phasors, and only a step confined to one phase may start pickup.
package open_phase_pkg;
  typedef enum logic [2:0] {
    FN_DISABLED = 3'b000,
    FN_TRIP     = 3'b001,
    FN_ALARM    = 3'b010,
    FN_LATCHED  = 3'b011,
    FN_CONTROL  = 3'b100
  } func_t;

  // Currents in units of 0.01 x CT, ratio in units of 0.1 percent.
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned TICK_MS        = 1;
  localparam int unsigned TICK_CYCLES    = CLK_HZ / 1000 * TICK_MS;
  localparam logic [16:0] TICK_LAST      = 17'(TICK_CYCLES - 1);
  localparam logic [15:0] STEP_LIMIT     = 16'h0005;
  localparam logic [9:0]  RATIO_MIN      = 10'h0C8;
  localparam logic [9:0]  RATIO_MAX      = 10'h3E8;
  localparam logic [9:0]  RATIO_RST      = 10'h0C8;
  localparam logic [15:0] FLOOR_MIN      = 16'h0005;
  localparam logic [15:0] FLOOR_MAX      = 16'h0064;
  localparam logic [15:0] FLOOR_RST      = 16'h000A;
  localparam logic [15:0] CEIL_MIN       = 16'h0005;
  localparam logic [15:0] CEIL_MAX       = 16'h01F4;
  localparam logic [15:0] CEIL_RST       = 16'h000A;
  localparam logic [15:0] DELAY_MAX      = 16'hEA60;
  localparam logic [15:0] DELAY_RST      = 16'h4E20;
  // Dropout at 97.5 percent: ratio*40 < setting*39.
  localparam logic [5:0]  DROP_NUM       = 6'h27;
  localparam logic [5:0]  DROP_DEN       = 6'h28;

  localparam logic [7:0]  A_CTRL         = 8'h00;
  localparam logic [7:0]  A_RATIO        = 8'h04;
  localparam logic [7:0]  A_FLOOR        = 8'h08;
  localparam logic [7:0]  A_CEIL         = 8'h0C;
  localparam logic [7:0]  A_DELAY        = 8'h10;
  localparam logic [7:0]  A_STATE        = 8'h14;
  localparam logic [7:0]  A_IRQ_STAT     = 8'h18;
  localparam logic [7:0]  A_IRQ_MASK     = 8'h1C;
  localparam int          IRQ_PKP_BIT    = 0;
  localparam int          IRQ_TRIP_BIT   = 1;
  localparam int          IRQ_DROP_BIT   = 2;
endpackage

// *** tb/fe_model.sv ***
`timescale 1ns/1ns
module fe_model (
  input  wire logic        pclk,
  output logic             meas_valid,
  output logic [15:0]      ia_mag,
  output logic [15:0]      ib_mag,
  output logic [15:0]      ic_mag,
  output logic [15:0]      i1_mag,
  output logic [15:0]      i2_mag
);
  initial begin
    meas_valid = 1'b0;
    ia_mag = 16'h0064;
    ib_mag = 16'h0064;
    ic_mag = 16'h0064;
    i1_mag = 16'h0000;
    i2_mag = 16'h0000;
  end

  // Sequence and phase magnitudes land together, so the element never sees a mixed set.
  task automatic send(input int a, input int b, input int c, input int p, input int n,
                      input int gap);
    repeat (gap) @(posedge pclk);
    @(posedge pclk);
    ia_mag     <= 16'(a);
    ib_mag     <= 16'(b);
    ic_mag     <= 16'(c);
    i1_mag     <= 16'(p);
    i2_mag     <= 16'(n);
    meas_valid <= 1'b1;
    @(posedge pclk);
    meas_valid <= 1'b0;
  endtask
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ns
module tb;
  import open_phase_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        meas_valid, er, pickup_q, trip_q, alarm_q, irq_q;
  logic [15:0] ia_mag, ib_mag, ic_mag, i1_mag, i2_mag;
  int          n_errors, checks, cyc, seed, fn_m, p;
  int          cur[4] = '{200, 10, 10, 20000};
  int          lo[4]  = '{200, 5, 5, 0};
  int          hi[4]  = '{1000, 100, 500, 60000};
  logic [7:0]  sa[4]  = '{A_RATIO, A_FLOOR, A_CEIL, A_DELAY};

  open_phase_element dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .meas_valid(meas_valid), .ia_mag(ia_mag), .ib_mag(ib_mag),
    .ic_mag(ic_mag), .i1_mag(i1_mag), .i2_mag(i2_mag), .pickup_q(pickup_q),
    .trip_q(trip_q), .alarm_q(alarm_q), .irq_q(irq_q));
  fe_model fe (.pclk(pclk), .meas_valid(meas_valid), .ia_mag(ia_mag), .ib_mag(ib_mag),
    .ic_mag(ic_mag), .i1_mag(i1_mag), .i2_mag(i2_mag));

  always #5 pclk = ~pclk;

  task automatic complete_run;
    if (n_errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      complete_run;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input int e);
    apb(1'b0, a, 32'h0);
    chk(rd, 32'(e));
    chkb(er, 1'b0);
  endtask

  // Out-of-range values leave the stored setting untouched.
  task automatic setr(input int i, input int v);
    apb(1'b1, sa[i], 32'(v));
    if (v >= lo[i] && v <= hi[i]) cur[i] = v;
  endtask

  task automatic ctl(input int f);
    apb(1'b1, A_CTRL, 32'(f));
    fn_m = f % 16;
  endtask

  // A balanced baseline with no negative sequence first, so only the second sample can start pickup.
  task automatic try(input int p, input int n, input int da, input int db, input int dc);
    fe.send(100, 100, 100, p, 0, 0);
    fe.send(100 - da, 100 - db, 100 - dc, p, n, $unsigned($random(seed)) % 3);
    repeat (3) @(posedge pclk);
    chkb(pickup_q, fn_m != 0 && n * 1000 > cur[0] * p && p >= cur[1] && p <= cur[2]
         && (da > 5) + (db > 5) + (dc > 5) == 1);
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {n_errors, checks, cyc, fn_m} = '0;
    seed = 32'h7C9A;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(A_CTRL, 0);
    apb(1'b0, 8'h40, 32'h0);
    chkb(er, 1'b1);
    chk(rd, 32'h0);
    for (int i = 0; i < 4; i++) begin
      rdchk(sa[i], cur[i]);
      setr(i, hi[i] + 1);
      setr(i, lo[i] - 1);
      rdchk(sa[i], cur[i]);
      setr(i, hi[i]);
      rdchk(sa[i], cur[i]);
    end
    setr(0, 300);
    setr(1, 10);
    setr(2, 200);
    setr(3, 1);
    try(100, 40, 50, 0, 0);
    chkb(trip_q, 1'b0);
    ctl(FN_TRIP);
    try(100, 40, 50, 0, 0);
    try(100, 40, 50, 50, 50);
    try(100, 40, 6, 0, 0);
    try(100, 40, 5, 0, 0);
    try(100, 30, 50, 0, 0);
    try(9, 5, 50, 0, 0);
    try(201, 100, 50, 0, 0);
    apb(1'b1, A_IRQ_STAT, 32'h7);
    try(200, 61, 50, 0, 0);
    fe.send(50, 100, 100, 200, 59, 0);
    repeat (3) @(posedge pclk);
    chkb(pickup_q, 1'b1);
    fe.send(50, 100, 100, 200, 58, 0);
    repeat (3) @(posedge pclk);
    chkb(pickup_q, 1'b0);
    chkb(trip_q, 1'b0);
    rdchk(A_IRQ_STAT, 5);
    apb(1'b1, A_IRQ_MASK, 32'h7);
    repeat (2) @(posedge pclk);
    chkb(irq_q, 1'b1);
    apb(1'b1, A_IRQ_MASK, 32'h0);
    repeat (2) @(posedge pclk);
    chkb(irq_q, 1'b0);
    apb(1'b1, A_IRQ_STAT, 32'h1);
    rdchk(A_IRQ_STAT, 4);
    apb(1'b1, A_IRQ_MASK, 32'h4);
    repeat (2) @(posedge pclk);
    chkb(irq_q, 1'b1);
    apb(1'b1, A_IRQ_STAT, 32'h4);
    repeat (2) @(posedge pclk);
    chkb(irq_q, 1'b0);
    setr(3, 0);
    for (int f = 0; f < 5; f++) begin
      ctl(f);
      try(100, 40, 50, 0, 0);
      repeat (5) @(posedge pclk);
      chkb(trip_q, f == 1 || f == 4);
      chkb(alarm_q, f == 2 || f == 3);
      fe.send(50, 100, 100, 100, 0, 0);
      repeat (3) @(posedge pclk);
      chkb(alarm_q, f == 3);
      ctl(f + 16);
      repeat (2) @(posedge pclk);
      chkb(alarm_q, 1'b0);
    end
    ctl(FN_CONTROL);
    for (int k = 0; k < 16; k++) begin
      p = 10 + $unsigned($random(seed)) % 191;
      try(p, $unsigned($random(seed)) % p, $unsigned($random(seed)) % 12, 0, 0);
    end
    complete_run;
  end
endmodule
